//--- inc/emb_pkg.sv
/*
 Shared constants and types of the external memory bus sequencer and the
 register file address decoder. Assumes a 100 MHz core clock.
*/
package emb_pkg;
	// Core clock period
	localparam int TPC_NS = 10;
	// Bus phase times, least values
	localparam int AS_LOW_NS  = 55;  // Address strobe low width
	localparam int AHOLD_NS   = 45;  // Address held after strobe rises
	localparam int AS_DSTB_NS = 55;  // Strobe rise to data strobe fall
	localparam int DSR_NS     = 185; // Data strobe low, read
	localparam int DSW_NS     = 110; // Data strobe low, write
	localparam int EXT_NS     = 250; // Extra data phase, slow memory
	localparam int RECOV_NS   = 55;  // Data strobe rise to next address
	localparam logic [5:0] AS_CYC    = 6'((AS_LOW_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] AHOLD_CYC = 6'((AHOLD_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] ASDS_CYC  = 6'((AS_DSTB_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] SETUP_CYC = ASDS_CYC - AHOLD_CYC;
	localparam logic [5:0] DSR_CYC   = 6'((DSR_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] DSW_CYC   = 6'((DSW_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] EXT_CYC   = 6'((EXT_NS + TPC_NS - 1) / TPC_NS);
	localparam logic [5:0] RECOV_CYC = 6'((RECOV_NS + TPC_NS - 1) / TPC_NS);
	// Register file map
	localparam logic [7:0] RA_CTLMODE = 8'hf7; // Control port mode
	localparam logic [7:0] RA_UPMODE  = 8'hf8; // Upper port mode
	localparam logic [7:0] RA_PTR     = 8'hfd; // Working group pointer
	localparam logic [7:0] RA_SPH     = 8'hfe; // stack_pointer_high
	localparam logic [7:0] RA_SPL     = 8'hff; // stack_pointer_low
	localparam logic [7:0] RA_PORT0   = 8'h00;
	localparam logic [7:0] RA_PORT2   = 8'h02;
	localparam logic [7:0] RA_PORT3   = 8'h03;
	localparam logic [7:0] RA_GPR_LO  = 8'h04;
	localparam logic [7:0] RA_GPR_HI  = 8'h7f;
	localparam logic [7:0] RA_CTL_LO  = 8'hf0;
	localparam logic [7:0] RD_NONE    = 8'hff; // Read of unreadable register
	// Upper port mode fields
	localparam int UPM_LO   = 0; // Low nibble carries address
	localparam int UPM_HI   = 1; // High nibble carries address
	localparam int UPM_EXT  = 2; // Extended memory timing
	localparam int UPM_ISTK = 3; // Stack in register file
	localparam logic [7:0] UPM_RST_V0 = 8'h04;
	localparam logic [7:0] UPM_RST_V1 = 8'h03;
	// Control port mode field and reset
	localparam int CTM_DSEL = 4; // Data space select on bit 4
	localparam logic [7:0] CTM_RST = 8'h00;
	// Start and vector addresses per variant
	localparam logic [15:0] PC_RST_V0   = 16'h000c;
	localparam logic [15:0] PC_RST_V1   = 16'h0812;
	localparam logic [15:0] VEC_BASE_V1 = 16'h0800;
	localparam logic [15:0] VEC_STEP_V0 = 16'h0002;
	localparam logic [15:0] VEC_STEP_V1 = 16'h0003;

	typedef enum logic [5:0] {
		S_IDLE  = 6'b000001,
		S_ADDR  = 6'b000010,
		S_AHOLD = 6'b000100,
		S_SETUP = 6'b001000,
		S_DATA  = 6'b010000,
		S_RECOV = 6'b100000
	} emb_state_e;

	typedef enum logic [1:0] {
		CLS_NONE = 2'h0,
		CLS_PORT = 2'h1,
		CLS_GPR  = 2'h2,
		CLS_CTL  = 2'h3
	} emb_cls_e;

	typedef struct packed {
		logic        write;
		logic        data_space;
		logic [15:0] addr;
		logic [7:0]  wdata;
	} emb_req_s;
endpackage : emb_pkg

//--- design/emb_bus.sv
/*
 External memory bus sequencer with register file decoding, start
 address, vector and stack pointer forming. Assumes the processor core
 on the request side runs on mclk and holds a request until req_ready.
*/
`timescale 1ns/10ps
// Notes on behaviour
// - One address strobe pulse per bus cycle
// - Low address valid at strobe rising edge
// - One data strobe per transfer, data phase
// - Read/write low only for writes
// - Low address and data share one port
// - Upper port drives high address when enabled
// - Data space select marks data accesses
// - Start fetch at 12 or 2066
// - Variant one slow timing, two normal
// - Upper port floats or drives address
// - Variant one: six two-byte vectors at 0
// - Variant two: six jump vectors from 0800h
// - Decode ports, general and control registers
// - Any register reached by 8-bit address
// - Short operand joins pointer group nibble
// - Pointer holds active working group start
// - External stack uses 16-bit pointer pair
// - Internal stack uses low pointer only
module emb_bus #(
	parameter bit VARIANT = 1'b0
) (
	input  wire logic              mclk,
	input  wire logic              rst_b,
	input  wire logic              ce,
	input  wire logic              req_valid,
	input  wire emb_pkg::emb_req_s req,
	output logic                   req_ready,
	output logic                   done,
	output logic [7:0]             rdata,
	input  wire logic              rf_valid,
	input  wire logic              rf_write,
	input  wire logic              rf_short,
	input  wire logic [7:0]        rf_addr,
	input  wire logic [7:0]        rf_wdata,
	output logic [7:0]             rf_full_addr,
	output emb_pkg::emb_cls_e      rf_class,
	output logic [7:0]             rf_rdata,
	input  wire logic [2:0]        irq_sel,
	output logic [15:0]            vec_addr,
	output logic [15:0]            reset_pc,
	output logic [15:0]            stack_addr,
	output logic                   stack_internal,
	output logic                   addr_strobe_n,
	output logic                   data_strobe_n,
	output logic                   read_write_n,
	output logic                   data_space_select_n,
	input  wire logic [7:0]        low_addr_data_lines_i,
	output logic [7:0]             low_addr_data_lines_o,
	output logic                   low_addr_data_lines_oe,
	output logic [7:0]             upper_address_port_o,
	output logic [7:0]             upper_address_port_oe
);
	emb_pkg::emb_state_e state_q, state_d;
	emb_pkg::emb_req_s   cur_q, cur_d;
	emb_pkg::emb_cls_e   cls_w;
	logic [5:0]  cnt_q, cnt_d;
	logic        as_q, as_d, dstb_q, dstb_d, rw_q, rw_d, dsel_q, dsel_d;
	logic [7:0]  ado_q, ado_d, hio_q, hio_d, rdata_q, rdata_d;
	logic        adoe_q, adoe_d, rdy_q, rdy_d, done_q, done_d;
	logic [7:0]  sync1_q, sync2_q;
	logic [7:0]  upm_q, ctm_q, ptr_q, sph_q, spl_q;
	logic [7:0]  full_q, rfrd_q, rfrd_w, full_w;
	logic [1:0]  cls_q;
	logic [15:0] vec_q, pc_q, stk_q, vec_w, stk_w;
	logic        istk_q;
	logic        cnt_zero, ext_w, wr_w;
	logic [5:0]  dstb_len_w;

	// Start address and mode reset values differ per variant
	localparam logic [15:0] PC_RST  = VARIANT ? emb_pkg::PC_RST_V1 : emb_pkg::PC_RST_V0;
	localparam logic [7:0]  UPM_RST = VARIANT ? emb_pkg::UPM_RST_V1 : emb_pkg::UPM_RST_V0;

	// Register address forming and decode
	assign full_w = rf_short ? {ptr_q[7:4], rf_addr[3:0]} : rf_addr;
	assign cls_w  = (full_w == emb_pkg::RA_PORT0 || full_w == emb_pkg::RA_PORT2 ||
			full_w == emb_pkg::RA_PORT3) ? emb_pkg::CLS_PORT :
			(full_w >= emb_pkg::RA_GPR_LO && full_w <= emb_pkg::RA_GPR_HI) ?
			emb_pkg::CLS_GPR :
			(full_w >= emb_pkg::RA_CTL_LO) ? emb_pkg::CLS_CTL : emb_pkg::CLS_NONE;
	// Mode registers are write-only and read back as all ones
	assign rfrd_w = (full_w == emb_pkg::RA_PTR) ? ptr_q :
			(full_w == emb_pkg::RA_SPH) ? sph_q :
			(full_w == emb_pkg::RA_SPL) ? spl_q : emb_pkg::RD_NONE;
	assign vec_w = VARIANT ? 16'(emb_pkg::VEC_BASE_V1 + emb_pkg::VEC_STEP_V1 * irq_sel) :
			16'(emb_pkg::VEC_STEP_V0 * irq_sel);
	assign stk_w = upm_q[emb_pkg::UPM_ISTK] ? {8'h00, spl_q} : {sph_q, spl_q};

	// Bus sequencing decode
	assign cnt_zero = (cnt_q == 6'h00);
	assign ext_w    = upm_q[emb_pkg::UPM_EXT];
	assign wr_w     = cur_q.write;
	assign dstb_len_w = 6'((wr_w ? emb_pkg::DSW_CYC : emb_pkg::DSR_CYC) +
			(ext_w ? emb_pkg::EXT_CYC : 6'h00) - 6'h01);

	// Register writes; pointer and modes steer the bus and decode
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			upm_q <= UPM_RST;
			ctm_q <= emb_pkg::CTM_RST;
			ptr_q <= 8'h00;
			sph_q <= 8'h00;
			spl_q <= 8'h00;
		end else if (ce && rf_valid && rf_write) begin
			if (full_w == emb_pkg::RA_UPMODE) upm_q <= rf_wdata;
			if (full_w == emb_pkg::RA_CTLMODE) ctm_q <= rf_wdata;
			if (full_w == emb_pkg::RA_PTR) ptr_q <= rf_wdata;
			if (full_w == emb_pkg::RA_SPH) sph_q <= rf_wdata;
			if (full_w == emb_pkg::RA_SPL) spl_q <= rf_wdata;
		end
	end

	// Decode results, vector, stack and start address outputs
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			full_q <= 8'h00;
			cls_q  <= 2'h0;
			rfrd_q <= 8'h00;
			vec_q  <= 16'h0000;
			stk_q  <= 16'h0000;
			istk_q <= 1'b0;
			pc_q   <= PC_RST;
		end else if (ce) begin
			if (rf_valid) begin
				full_q <= full_w;
				cls_q  <= cls_w;
				rfrd_q <= rfrd_w;
			end
			vec_q  <= vec_w;
			stk_q  <= stk_w;
			istk_q <= upm_q[emb_pkg::UPM_ISTK];
		end
	end

	// Pin input synchroniser; only the second stage is read
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			sync1_q <= 8'h00;
			sync2_q <= 8'h00;
		end else if (ce) begin
			sync1_q <= low_addr_data_lines_i;
			sync2_q <= sync1_q;
		end
	end

	// Bus cycle sequencer; each phase held for a counted time
	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_zero ? cnt_q : cnt_q - 6'h01;
		cur_d   = cur_q;
		as_d    = as_q;
		dstb_d  = dstb_q;
		rw_d    = rw_q;
		dsel_d  = dsel_q;
		ado_d   = ado_q;
		adoe_d  = adoe_q;
		hio_d   = hio_q;
		rdy_d   = rdy_q;
		done_d  = 1'b0;
		rdata_d = rdata_q;
		unique case (state_q)
			emb_pkg::S_IDLE: if (req_valid && rdy_q) begin
				state_d = emb_pkg::S_ADDR;
				cnt_d   = emb_pkg::AS_CYC - 6'h01;
				cur_d   = req;
				rdy_d   = 1'b0;
				as_d    = 1'b0;
				ado_d   = req.addr[7:0];
				adoe_d  = 1'b1;
				hio_d   = req.addr[15:8];
				rw_d    = ~req.write;
				dsel_d  = ~(ctm_q[emb_pkg::CTM_DSEL] && req.data_space);
			end
			emb_pkg::S_ADDR: if (cnt_zero) begin
				// Strobe rises while the address still stands
				state_d = emb_pkg::S_AHOLD;
				cnt_d   = emb_pkg::AHOLD_CYC - 6'h01;
				as_d    = 1'b1;
			end
			emb_pkg::S_AHOLD: if (cnt_zero) begin
				state_d = emb_pkg::S_SETUP;
				cnt_d   = emb_pkg::SETUP_CYC - 6'h01;
				ado_d   = wr_w ? cur_q.wdata : ado_q;
				adoe_d  = wr_w;
			end
			emb_pkg::S_SETUP: if (cnt_zero) begin
				state_d = emb_pkg::S_DATA;
				cnt_d   = dstb_len_w;
				dstb_d  = 1'b0;
			end
			emb_pkg::S_DATA: if (cnt_zero) begin
				// Sample before the strobe rises; memory holds data until then
				state_d = emb_pkg::S_RECOV;
				cnt_d   = emb_pkg::RECOV_CYC - 6'h01;
				dstb_d  = 1'b1;
				rdata_d = wr_w ? rdata_q : sync2_q;
			end
			emb_pkg::S_RECOV: if (cnt_zero) begin
				// Write data held through recovery for memory hold time
				state_d = emb_pkg::S_IDLE;
				rw_d    = 1'b1;
				dsel_d  = 1'b1;
				adoe_d  = 1'b0;
				rdy_d   = 1'b1;
				done_d  = 1'b1;
			end
		endcase
	end

	// Sequencer and pin flops, frozen while ce is low
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= emb_pkg::S_IDLE;
			cnt_q   <= 6'h00;
			cur_q   <= '0;
			as_q    <= 1'b1;
			dstb_q  <= 1'b1;
			rw_q    <= 1'b1;
			dsel_q  <= 1'b1;
			ado_q   <= 8'h00;
			adoe_q  <= 1'b0;
			hio_q   <= 8'h00;
			rdy_q   <= 1'b1;
			done_q  <= 1'b0;
			rdata_q <= 8'h00;
		end else if (ce) begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
			cur_q   <= cur_d;
			as_q    <= as_d;
			dstb_q  <= dstb_d;
			rw_q    <= rw_d;
			dsel_q  <= dsel_d;
			ado_q   <= ado_d;
			adoe_q  <= adoe_d;
			hio_q   <= hio_d;
			rdy_q   <= rdy_d;
			done_q  <= done_d;
			rdata_q <= rdata_d;
		end
	end

	// Upper port enables follow the mode nibbles, registered
	logic [7:0] hioe_q;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			hioe_q <= 8'h00;
		end else if (ce) begin
			hioe_q <= {{4{upm_q[emb_pkg::UPM_HI]}}, {4{upm_q[emb_pkg::UPM_LO]}}};
		end
	end

	assign req_ready              = rdy_q;
	assign done                   = done_q;
	assign rdata                  = rdata_q;
	assign rf_full_addr           = full_q;
	assign rf_class               = emb_pkg::emb_cls_e'(cls_q);
	assign rf_rdata               = rfrd_q;
	assign vec_addr               = vec_q;
	assign reset_pc               = pc_q;
	assign stack_addr             = stk_q;
	assign stack_internal         = istk_q;
	assign addr_strobe_n          = as_q;
	assign data_strobe_n          = dstb_q;
	assign read_write_n           = rw_q;
	assign data_space_select_n    = dsel_q;
	assign low_addr_data_lines_o  = ado_q;
	assign low_addr_data_lines_oe = adoe_q;
	assign upper_address_port_o   = hio_q;
	assign upper_address_port_oe  = hioe_q;

	// Checks assume ce stays high during a bus cycle
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_b);

	a_as_pulse_width: assert property ($fell(as_q) |-> !as_q[*6] ##1 as_q[*5])
		else $error("address strobe width wrong");
	a_addr_at_rise: assert property ($rose(as_q) |-> adoe_q && ado_q == cur_q.addr[7:0])
		else $error("address not valid at strobe rise");
	a_dstb_once: assert property ($fell(dstb_q) |->
			as_q && state_q == emb_pkg::S_DATA ##1 !dstb_q)
		else $error("data strobe outside data phase");
	a_rw_write_only: assert property (!rw_q |-> cur_q.write && state_q != emb_pkg::S_IDLE)
		else $error("write level without write");
	a_read_float: assert property (!dstb_q && rw_q |-> !adoe_q)
		else $error("port driven during read data");
	a_write_setup: assert property ($fell(dstb_q) && !rw_q |->
			adoe_q && $past(adoe_q, 1) && ado_q == cur_q.wdata)
		else $error("write data not ahead of strobe");
	a_upper_addr: assert property (!as_q |-> hio_q == cur_q.addr[15:8])
		else $error("upper address wrong");
	a_dsel_space: assert property (!as_q && ctm_q[emb_pkg::CTM_DSEL] |->
			dsel_q == !cur_q.data_space)
		else $error("data space select wrong");
	a_done_bound: assert property ($fell(as_q) |-> ##[28:72] done_q)
		else $error("bus cycle did not end in time");
	a_short_operand: assert property (rf_valid && rf_short && !(rf_write &&
			full_w == emb_pkg::RA_PTR) |=> full_q == {$past(ptr_q[7:4]), $past(rf_addr[3:0])})
		else $error("short register address wrong");
	// Pointer pair compared as it stood when the address was formed
	a_stack_ext: assert property (!upm_q[emb_pkg::UPM_ISTK] |=>
			stk_q == {$past(sph_q), $past(spl_q)})
		else $error("external stack address wrong");

	c_read:  cover property ($fell(dstb_q) && rw_q);
	c_write: cover property ($fell(dstb_q) && !rw_q);
	c_ext:   cover property ($fell(dstb_q) && ext_w);
	c_b2b:   cover property (done_q ##1 !as_q);
endmodule : emb_bus

//--- tb/emb_mem_model.sv
/*
 Behavioural external program and data memory, 64K bytes each.
 Assumes the bench feeds ad_wire back into the sequencer's line input.
*/
`timescale 1ns/10ps
module emb_mem_model #(
	parameter int RD_DLY_NS = 40
) (
	input  wire logic        mclk,
	input  wire logic        addr_strobe_n,
	input  wire logic        data_strobe_n,
	input  wire logic        read_write_n,
	input  wire logic        data_space_select_n,
	input  wire logic [7:0]  ad_o,
	input  wire logic        ad_oe,
	input  wire logic [7:0]  up_o,
	input  wire logic [7:0]  up_oe,
	output logic      [7:0]  ad_wire,
	output logic      [15:0] lat_addr,
	output logic             lat_dsel_n
);
	logic [7:0] mem [2][65536];
	logic       drv;
	logic [7:0] park;
	// Preset contents so unwritten reads are predictable
	initial begin
		drv = 1'b0;
		park = 8'h00;
		for (int i = 0; i < 65536; i++) begin
			mem[0][i] = 8'(i) ^ 8'(i >> 8) ^ 8'hff;
			mem[1][i] = 8'(i) ^ 8'(i >> 8);
		end
	end
	// Address taken at strobe rise; undriven upper bits pulled to 0
	always @(posedge addr_strobe_n) begin
		lat_addr   <= {up_o & up_oe, ad_wire};
		lat_dsel_n <= data_space_select_n;
	end
	// Late drive models a slow part; released at strobe rise
	always @(negedge data_strobe_n) begin
		if (read_write_n) drv <= #(RD_DLY_NS) 1'b1;
	end
	always @(posedge data_strobe_n) begin
		drv <= 1'b0;
		if (!read_write_n) mem[lat_dsel_n][lat_addr] <= ad_wire;
	end
	// Lines nobody drives show the inverse of the last level
	always @(posedge mclk) begin
		if (ad_oe || drv) park <= ~ad_wire;
	end
	assign ad_wire = ad_oe ? ad_o : (drv ? mem[lat_dsel_n][lat_addr] : park);
endmodule : emb_mem_model

//--- tb/test_ext_memory_bus_and_register_map.sv
/*
 Self-checking bench for the bus sequencer, both variants, with a memory
 model on the multiplexed port. Assumes a 100 MHz mclk.
*/
`timescale 1ns/10ps
module test_ext_memory_bus_and_register_map;
	logic mclk, rst_b, req_valid, rf_valid, rf_write, rf_short;
	logic req_ready, done, stack_internal, rw_dstb, done_v1;
	logic addr_strobe_n, data_strobe_n, read_write_n, data_space_select_n;
	logic low_addr_data_lines_oe, lat_dsel_n;
	logic [7:0] rf_addr, rf_wdata, rdata, rf_full_addr, rf_rdata;
	logic [7:0] low_addr_data_lines_i, low_addr_data_lines_o;
	logic [7:0] upper_address_port_o, upper_address_port_oe, upoe_v1;
	logic [15:0] vec_addr, reset_pc, stack_addr, lat_addr, vec_v1, pc_v1;
	logic [2:0] irq_sel;
	emb_pkg::emb_req_s req;
	emb_pkg::emb_cls_e rf_class;
	wire logic ce = 1'b1;
	int n_fail = 0, checked = 0, n_as = 0, n_dstb = 0, cyc = 0, lat_v1 = 0;

	emb_bus #(.VARIANT(1'b0)) u_dut (.mclk, .rst_b, .ce, .req_valid, .req,
		.req_ready, .done, .rdata, .rf_valid, .rf_write, .rf_short, .rf_addr,
		.rf_wdata, .rf_full_addr, .rf_class, .rf_rdata, .irq_sel, .vec_addr,
		.reset_pc, .stack_addr, .stack_internal, .addr_strobe_n, .data_strobe_n,
		.read_write_n, .data_space_select_n, .low_addr_data_lines_i,
		.low_addr_data_lines_o, .low_addr_data_lines_oe, .upper_address_port_o,
		.upper_address_port_oe);
	emb_mem_model u_mem (.mclk, .addr_strobe_n, .data_strobe_n, .read_write_n,
		.data_space_select_n, .ad_o(low_addr_data_lines_o),
		.ad_oe(low_addr_data_lines_oe), .up_o(upper_address_port_o),
		.up_oe(upper_address_port_oe), .ad_wire(low_addr_data_lines_i),
		.lat_addr, .lat_dsel_n);
	// Second variant shares every input; only its own outputs are checked
	emb_bus #(.VARIANT(1'b1)) u_dut_v1 (.mclk, .rst_b, .ce, .req_valid, .req,
		.req_ready(), .done(done_v1), .rdata(), .rf_valid, .rf_write, .rf_short,
		.rf_addr, .rf_wdata, .rf_full_addr(), .rf_class(), .rf_rdata(), .irq_sel,
		.vec_addr(vec_v1), .reset_pc(pc_v1), .stack_addr(), .stack_internal(),
		.addr_strobe_n(), .data_strobe_n(), .read_write_n(), .data_space_select_n(),
		.low_addr_data_lines_i, .low_addr_data_lines_o(), .low_addr_data_lines_oe(),
		.upper_address_port_o(), .upper_address_port_oe(upoe_v1));

	// Clock, strobe counters and hang guard
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	always @(negedge addr_strobe_n) n_as++;
	always @(negedge data_strobe_n) begin
		n_dstb++;
		rw_dstb = read_write_n;
	end
	always @(posedge mclk) begin
		cyc++;
		if (cyc == 3000) begin
			n_fail++;
			complete_run;
		end
	end

	task automatic complete_run;
		$display("checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask : complete_run

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk

	// One register access, results settled on return
	task automatic rf(input logic w, input logic s, input logic [7:0] a, input logic [7:0] d);
		@(negedge mclk);
		{rf_valid, rf_write, rf_short, rf_addr, rf_wdata} = {1'b1, w, s, a, d};
		@(negedge mclk);
		{rf_valid, rf_write, rf_short} = 3'h0;
	endtask : rf

	// One bus cycle; latency is one more than the cycles from the taking edge to done
	task automatic bus(input logic w, input logic dsp, input logic [15:0] a,
		input logic [7:0] wd, output int lat);
		@(negedge mclk);
		req_valid = 1'b1;
		req = '{w, dsp, a, wd};
		n_as = 0;
		n_dstb = 0;
		// Ready looked at settled; the next rising edge takes the request
		while (req_ready !== 1'b1) @(negedge mclk);
		@(negedge mclk);
		req_valid = 1'b0;
		lat = 1;
		lat_v1 = 0;
		while (done !== 1'b1 && lat < 200) begin
			@(negedge mclk);
			lat++;
			if (done_v1 === 1'b1) lat_v1 = lat;
		end
		chk("done_seen", 16'h0001, {15'h0, done});
		chk("as_pulses", 16'h0001, 16'(n_as));
		chk("dstb_pulses", 16'h0001, 16'(n_dstb));
		chk("rw_at_dstb", {15'h0, !w}, {15'h0, rw_dstb});
	endtask : bus

	function automatic logic [15:0] pat(input logic [15:0] a, input logic dsp);
		return {8'h00, a[7:0] ^ a[15:8] ^ (dsp ? 8'hff : 8'h00)};
	endfunction : pat

	initial begin
		int l1;
		int l2;
		logic [7:0] ra [7];
		logic [1:0] rc [7];
		ra = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h7f, 8'h80, 8'hf0};
		rc = '{2'h1, 2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h3};
		{rst_b, req_valid, rf_valid, rf_write, rf_short} = 5'h0;
		{rf_addr, rf_wdata, irq_sel} = 19'h0;
		req = '0;
		repeat (3) @(posedge mclk);
		@(negedge mclk) rst_b = 1'b1;
		chk("reset_pc", 16'h000c, reset_pc);
		chk("reset_pc_v1", 16'h0812, pc_v1);
		chk("upper_oe", 16'h0000, 16'(upper_address_port_oe));
		for (int n = 0; n < 6; n++) begin
			@(negedge mclk) irq_sel = 3'(n);
			@(negedge mclk) chk("vec_addr", 16'(2 * n), vec_addr);
			chk("vec_v1", 16'h0800 + 16'(3 * n), vec_v1);
		end
		chk("upper_oe_v1", 16'h00ff, 16'(upoe_v1));
		rf(0, 0, 8'hfe, 8'h00);
		chk("sph_reset", 16'h0000, 16'(rf_rdata));
		// First read: slow timing, upper port still floating
		bus(0, 0, 16'h1234, 8'h00, l1);
		chk("lat_addr", 16'h0034, lat_addr);
		chk("rdata", pat(16'h0034, 0), 16'(rdata));
		// Second variant ran the same read with normal timing
		chk("v1_extra", 16'(emb_pkg::EXT_CYC), 16'(l1 - lat_v1));
		rf(1, 0, 8'hf8, 8'h03);
		rf(1, 0, 8'hf7, 8'h10);
		repeat (2) @(negedge mclk);
		chk("upper_oe", 16'h00ff, 16'(upper_address_port_oe));
		bus(0, 0, 16'h1234, 8'h00, l2);
		chk("lat_addr", 16'h1234, lat_addr);
		chk("ext_extra", 16'(emb_pkg::EXT_CYC), 16'(l1 - l2));
		chk("dsel_prog", 16'h0001, 16'(lat_dsel_n));
		chk("rdata", pat(16'h1234, 0), 16'(rdata));
		// Data space write, read back, then program space at same address
		bus(1, 1, 16'habcd, 8'h3c, l1);
		chk("dsel_data", 16'h0000, 16'(lat_dsel_n));
		bus(0, 1, 16'habcd, 8'h00, l1);
		chk("rdata", 16'h003c, 16'(rdata));
		bus(0, 0, 16'habcd, 8'h00, l1);
		chk("rdata", pat(16'habcd, 0), 16'(rdata));
		for (int i = 0; i < 7; i++) begin
			rf(0, 0, ra[i], 8'h00);
			chk("rf_class", 16'(rc[i]), 16'(rf_class));
			chk("rf_full", 16'(ra[i]), 16'(rf_full_addr));
		end
		rf(1, 0, 8'hfd, 8'h20);
		rf(0, 1, 8'h05, 8'h00);
		chk("rf_full", 16'h0025, 16'(rf_full_addr));
		rf(1, 0, 8'hfe, 8'h12);
		rf(1, 0, 8'hff, 8'h34);
		@(negedge mclk);
		chk("stack_addr", 16'h1234, stack_addr);
		chk("stk_int", 16'h0000, 16'(stack_internal));
		rf(1, 0, 8'hf8, 8'h0b);
		@(negedge mclk);
		chk("stack_addr", 16'h0034, stack_addr);
		chk("stk_int", 16'h0001, 16'(stack_internal));
		rf(0, 0, 8'hfe, 8'h00);
		chk("sph_read", 16'h0012, 16'(rf_rdata));
		complete_run;
	end
endmodule : test_ext_memory_bus_and_register_map
